// *** fbs_sram_access.sv ***
// Flow-through burst SRAM access logic with read stream buffer
//
// Notes on behaviour
// - Input lanes captured into data register
// - Driven data is word of latched address
// - Output enable high forces lanes high-impedance
// - Hi-Z on write data, deselect, emergence
// - Parity lanes act as data, byte-gated
// - Strap high interleaved, low linear, default high
// - Clock enable high freezes every state
// - Selected load edge latches address, starts access
// - Write enable picks read or write
// - Read needs all selects, enables, load
// - Drivers follow enable as sampled at the read edge
// - Next operation accepted on following edge
// - Deselect edge makes outputs high-impedance
// - Advance high steps internal burst counter
// - Byte selects gate own byte and parity
// - Two-bit counter, linear add, interleaved xor
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Buffer with registered head
// ----------------------------------------------------------------------
module fbs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,     // Clock
    input  wire logic             rst_b_i,   // Async reset, active low
    input  wire logic             ce_i,      // Clock enable, high runs
    input  wire logic             in_valid_i, // Word offered
    output logic                  in_ready_o, // Room for a word
    input  wire logic [WIDTH-1:0] in_data_i, // Word in
    output logic                  out_valid_o, // Head word valid
    input  wire logic             out_ready_i, // Consumer takes head
    output logic      [WIDTH-1:0] out_data_o // Head word
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [PW-1:0]  wptr;
        logic [PW-1:0]  rptr;
        logic [PW:0]    count;
        logic           hvalid;
        logic [WIDTH-1:0] hdata;
    } fbs_fifo_state_type;

    logic [WIDTH-1:0]   store [DEPTH];
    fbs_fifo_state_type st_reg;
    fbs_fifo_state_type st_next;
    logic               push;
    logic               pop;

    assign in_ready_o  = (st_reg.count != DEPTH[PW:0]);
    assign out_valid_o = st_reg.hvalid;
    assign out_data_o  = st_reg.hdata;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = (st_reg.count != '0) &&
                         (!st_reg.hvalid || out_ready_i);

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wptr = st_reg.wptr + 1'b1;
        end
        if (pop) begin
            st_next.rptr   = st_reg.rptr + 1'b1;
            st_next.hvalid = 1'b1;
            st_next.hdata  = store[st_reg.rptr];
        end else if (out_ready_i) begin
            st_next.hvalid = 1'b0;
        end
        st_next.count = st_reg.count + {{PW{1'b0}}, push}
                                     - {{PW{1'b0}}, pop};
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            store[st_reg.wptr] <= in_data_i;
        end
    end

endmodule // fbs_fifo

// ----------------------------------------------------------------------
// SRAM access top
// ----------------------------------------------------------------------
module fbs_sram_access
    import fbs_pkg::*;
(
    input  wire logic              clk_i,              // 10 MHz clock
    input  wire logic              rst_b_i,            // Async reset
    input  wire logic              clock_enable_n_i,   // Low runs
    input  wire logic              chip_select_1_n_i,  // Select, low
    input  wire logic              chip_select_2_i,    // Select, high
    input  wire logic              chip_select_3_n_i,  // Select, low
    input  wire logic              advance_load_i,     // High advances
    input  wire logic              write_enable_n_i,   // Low writes
    input  wire logic [LANES-1:0]  byte_lane_select_n_i, // Byte selects
    input  wire logic              output_enable_n_i,  // Low drives
    input  wire logic              burst_order_i,      // Strap
    input  wire logic [ADDR_W-1:0] address_i,          // Word address
    input  wire logic [DATA_W-1:0] data_lanes_i,       // Data pins in
    output logic      [DATA_W-1:0] data_lanes_o,       // Data pins out
    output logic                   data_lanes_oe_b_o,  // Low drives
    input  wire logic [LANES-1:0]  parity_lanes_i,     // Parity in
    output logic      [LANES-1:0]  parity_lanes_o,     // Parity out
    output logic                   parity_lanes_oe_b_o, // Low drives
    output logic                   rd_stream_valid_o,  // Stream word
    input  wire logic              rd_stream_ready_i,  // Stream taken
    output logic      [WORD_W-1:0] rd_stream_data_o,   // Read word copy
    output logic                   rd_stream_ovf_o     // Word dropped
);

    typedef struct packed {
        logic               burst_act;
        logic               is_write;
        logic [ADDR_W-1:0]  base_addr;
        logic [BURST_W-1:0] step;
        logic               wr_act;
        logic [ADDR_W-1:0]  wr_addr;
        logic [LANES-1:0]   wr_bws_n;
        logic [WORD_W-1:0]  din;
        logic [WORD_W-1:0]  dout;
        logic               oe_b;
        fbs_order_type      order;
        logic               ovf;
    } fbs_state_type;

    logic [WORD_W-1:0] mem [MEM_DEPTH];
    fbs_state_type     st_reg;
    fbs_state_type     st_next;
    logic              ce;
    logic              sel_all;
    logic              load;
    logic              advance;
    logic              access;
    logic              cur_write;
    logic [ADDR_W-1:0] cur_addr;
    logic [WORD_W-1:0] pin_word;
    logic [WORD_W-1:0] rd_word;
    logic              buf_ready;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [BURST_W-1:0] burst_next(
        input fbs_order_type      ord,
        input logic [BURST_W-1:0] first,
        input logic [BURST_W-1:0] idx
    );
        if (ord == FBS_INTERLEAVED) begin
            return first ^ idx;
        end
        return first + idx;
    endfunction

    function automatic logic [WORD_W-1:0] lane_merge(
        input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w,
        input logic [LANES-1:0]  bws_n
    );
        logic [WORD_W-1:0] res;
        res = old_w;
        for (int k = 0; k < LANES; k++) begin
            if (!bws_n[k]) begin
                res[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
                res[DATA_W + k]         = new_w[DATA_W + k];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    assign ce        = !clock_enable_n_i;
    assign sel_all   = !chip_select_1_n_i && chip_select_2_i &&
                       !chip_select_3_n_i;
    assign load      = sel_all && !advance_load_i;
    assign advance   = advance_load_i && st_reg.burst_act;
    assign access    = load || advance;
    assign cur_write = load ? !write_enable_n_i
                            : st_reg.is_write;
    assign cur_addr  = load ? address_i
                     : {st_reg.base_addr[ADDR_W-1:BURST_W],
                        burst_next(st_reg.order,
                                   st_reg.base_addr[BURST_W-1:0],
                                   st_reg.step + 2'h1)};
    assign pin_word  = {parity_lanes_i, data_lanes_i};

    // Pending write lands this edge, so forward it to a same-word read
    always_comb begin
        rd_word = mem[cur_addr];
        if (st_reg.wr_act && st_reg.wr_addr == cur_addr) begin
            rd_word = lane_merge(rd_word, pin_word, st_reg.wr_bws_n);
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.din   = pin_word;
        st_next.order = fbs_order_type'(burst_order_i);
        st_next.wr_act = access && cur_write;
        if (load) begin
            st_next.burst_act = 1'b1;
            st_next.is_write  = !write_enable_n_i;
            st_next.base_addr = address_i;
            st_next.step      = STEP_RST;
        end else if (advance_load_i) begin
            st_next.step = st_reg.step + 2'h1;
        end else begin
            st_next.burst_act = 1'b0;
        end
        if (access && cur_write) begin
            st_next.wr_addr  = cur_addr;
            st_next.wr_bws_n = byte_lane_select_n_i;
        end
        // Drive only in the data phase of a read with enable low
        st_next.oe_b = !(access && !cur_write)
                       || output_enable_n_i;
        if (access && !cur_write) begin
            st_next.dout = rd_word;
        end
        if (access && !cur_write && !buf_ready) begin
            st_next.ovf = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg           <= '0;
            st_reg.wr_bws_n  <= LANE_RST;
            st_reg.oe_b      <= 1'b1;
            st_reg.order     <= fbs_order_type'(ORDER_RST);
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Late write: data sampled one edge after its address
    always_ff @(posedge clk_i) begin
        if (ce && st_reg.wr_act) begin
            mem[st_reg.wr_addr] <= lane_merge(mem[st_reg.wr_addr],
                                              pin_word,
                                              st_reg.wr_bws_n);
        end
    end

    // ------------------------------------------------------------------
    // Read stream buffer
    // ------------------------------------------------------------------
    fbs_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_rd_buf (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .ce_i        (ce),
        .in_valid_i  (access && !cur_write),
        .in_ready_o  (buf_ready),
        .in_data_i   (rd_word),
        .out_valid_o (rd_stream_valid_o),
        .out_ready_i (rd_stream_ready_i),
        .out_data_o  (rd_stream_data_o)
    );

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    assign data_lanes_o        = st_reg.dout[DATA_W-1:0];
    assign parity_lanes_o      = st_reg.dout[WORD_W-1:DATA_W];
    assign data_lanes_oe_b_o   = st_reg.oe_b;
    assign parity_lanes_oe_b_o = st_reg.oe_b;
    assign rd_stream_ovf_o     = st_reg.ovf;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_freeze_hold: assert property (
        clock_enable_n_i |=> $stable(st_reg))
        else $error("State moved while clock enable was high");

    chk_addr_latch: assert property (
        ce && load |=> st_reg.base_addr == $past(address_i)
                       && st_reg.step == STEP_RST)
        else $error("Address not latched on load");

    chk_write_type: assert property (
        ce && load |=> st_reg.is_write == !$past(write_enable_n_i))
        else $error("Access type not taken from write enable");

    chk_read_drive: assert property (
        ce && sel_all && !advance_load_i && write_enable_n_i
        && !output_enable_n_i |=> !data_lanes_oe_b_o)
        else $error("Read with enable low did not drive");

    chk_oe_high_hiz: assert property (
        ce && output_enable_n_i |=> data_lanes_oe_b_o)
        else $error("Lanes driven with output enable high");

    chk_write_hiz: assert property (
        ce && access && cur_write |=> data_lanes_oe_b_o
                                      && st_reg.wr_act)
        else $error("Lanes driven in write data phase");

    chk_desel_hiz: assert property (
        ce && !sel_all && !advance_load_i |=> data_lanes_oe_b_o)
        else $error("Lanes driven after deselect");

    chk_parity_lane: assert property (
        ce && st_reg.wr_act |=>
            ((mem[$past(st_reg.wr_addr)][WORD_W-1:DATA_W]
              ^ $past(mem[st_reg.wr_addr][WORD_W-1:DATA_W]))
             & $past(st_reg.wr_bws_n)) == '0)
        else $error("Parity lane written without its byte select");

    chk_capture_in: assert property (
        ce |=> st_reg.din == $past(pin_word))
        else $error("Input lanes not captured");

    chk_read_data: assert property (
        ce && access && !cur_write |=> st_reg.dout == $past(rd_word))
        else $error("Read data not from latched word");

    chk_burst_step: assert property (
        ce && advance |->
            cur_addr[ADDR_W-1:BURST_W] == st_reg.base_addr[ADDR_W-1:BURST_W]
            && ((st_reg.order == FBS_LINEAR)
                ? cur_addr[BURST_W-1:0] - st_reg.base_addr[BURST_W-1:0]
                : cur_addr[BURST_W-1:0] ^ st_reg.base_addr[BURST_W-1:0])
               == st_reg.step + 2'h1)
        else $error("Burst address out of order");

    chk_back_back: assert property (
        ce && load && write_enable_n_i ##1 ce && load
        && !write_enable_n_i |=> st_reg.wr_act && data_lanes_oe_b_o)
        else $error("Write after read not accepted");

    cov_read:   cover property (ce && load && write_enable_n_i);
    cov_write:  cover property (ce && load && !write_enable_n_i);
    cov_burst:  cover property (ce && advance ##1 ce && advance);
    cov_freeze: cover property (ce && access ##1 clock_enable_n_i);

endmodule // fbs_sram_access

// *** fbs_pkg.sv ***
// Constants and types for the flow-through burst SRAM access block
package fbs_pkg;

    // ------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 18;
    localparam int DATA_W     = 32;
    localparam int LANES      = 4;
    localparam int LANE_W     = 8;
    localparam int WORD_W     = DATA_W + LANES;
    localparam int MEM_DEPTH  = 1 << ADDR_W;
    localparam int BUF_DEPTH  = 8;
    localparam int BURST_W    = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic               ORDER_RST  = 1'b1;
    localparam logic [BURST_W-1:0] STEP_RST   = 2'h0;
    localparam logic [ADDR_W-1:0]  ADDR_RST   = 18'h00000;
    localparam logic [LANES-1:0]   LANE_RST   = 4'hf;
    localparam logic [WORD_W-1:0]  WORD_RST   = 36'h000000000;

    typedef enum logic {
        FBS_LINEAR      = 1'b0,
        FBS_INTERLEAVED = 1'b1
    } fbs_order_type;

endpackage

// *** fbs_ctrl_model.sv ***
// Controller-side model: write data drive and shared lane resolution
`timescale 1ns/1ps

module fbs_ctrl_model
    import fbs_pkg::*;
(
    input  wire logic              clk_i,      // Clock
    input  wire logic              ce_n_i,     // Clock enable at pins
    input  wire logic              wr_i,       // Data phase follows edge
    input  wire logic [WORD_W-1:0] wdata_i,    // Word for data phase
    input  wire logic [WORD_W-1:0] dev_data_i, // Device lanes out
    input  wire logic              dev_oe_b_i, // Device drives when low
    output logic      [WORD_W-1:0] lane_o,     // Resolved lanes
    output logic                   clash_o     // Both sides driving
);
    logic              drv_reg = 1'b0;
    logic [WORD_W-1:0] wd_reg  = 36'h000000000;
    logic [WORD_W-1:0] flt_reg = 36'h000000000;

    // Data phase held over suspended edges
    always_ff @(posedge clk_i) begin
        if (!ce_n_i) begin
            drv_reg <= wr_i;
            wd_reg  <= wdata_i;
        end
        flt_reg <= ~lane_o;
    end

    // Released lanes flip every cycle so stale data never passes
    always_comb begin
        if (!dev_oe_b_i) lane_o = dev_data_i;
        else if (drv_reg) lane_o = wd_reg;
        else lane_o = flt_reg;
    end

    assign clash_o = !dev_oe_b_i && drv_reg;
endmodule // fbs_ctrl_model

// *** fbs_sram_access_test.sv ***
// Self-checking bench for the flow-through burst SRAM access block
`timescale 1ns/1ps
`define FBS_CHK(n, e, g) chk(n, 64'(e), 64'(g))

module fbs_sram_access_test
    import fbs_pkg::*;
;
    localparam logic [2:0] DESEL [3] = '{3'h6, 3'h0, 3'h3};
    logic              clk   = 1'b0;
    logic              rst_b = 1'b0;
    logic              ce_n  = 1'b1;
    logic              cs1_n = 1'b1;
    logic              cs2   = 1'b0;
    logic              cs3_n = 1'b1;
    logic              adv   = 1'b0;
    logic              we_n  = 1'b1;
    logic [LANES-1:0]  bws_n = 4'hf;
    logic              oe_n  = 1'b1;
    logic              ord   = 1'b1;
    logic [ADDR_W-1:0] addr  = 18'h00000;
    logic              wr    = 1'b0;
    logic [WORD_W-1:0] wdata = 36'h000000000;
    logic              rdy   = 1'b0;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0]  pout;
    logic              oe_b, poe_b, sv, ovf, clash;
    logic [WORD_W-1:0] sd, lane;
    logic [WORD_W-1:0] mem [int];
    logic [WORD_W-1:0] exp_pin [$];
    logic [WORD_W-1:0] exp_str [$];
    logic [ADDR_W-1:0] bb = 18'h00000;
    logic [1:0]        st = 2'h0;
    logic              bw = 1'b0, bopen = 1'b0, stall = 1'b0, drop = 1'b0;
    int                n_fail = 0;
    int                n_checks = 0;

    always #50 clk = ~clk;

    fbs_sram_access i_fbs_sram_access (
        .clk_i                (clk),
        .rst_b_i              (rst_b),
        .clock_enable_n_i     (ce_n),
        .chip_select_1_n_i    (cs1_n),
        .chip_select_2_i      (cs2),
        .chip_select_3_n_i    (cs3_n),
        .advance_load_i       (adv),
        .write_enable_n_i     (we_n),
        .byte_lane_select_n_i (bws_n),
        .output_enable_n_i    (oe_n),
        .burst_order_i        (ord),
        .address_i            (addr),
        .data_lanes_i         (lane[DATA_W-1:0]),
        .data_lanes_o         (dout),
        .data_lanes_oe_b_o    (oe_b),
        .parity_lanes_i       (lane[WORD_W-1:DATA_W]),
        .parity_lanes_o       (pout),
        .parity_lanes_oe_b_o  (poe_b),
        .rd_stream_valid_o    (sv),
        .rd_stream_ready_i    (rdy),
        .rd_stream_data_o     (sd),
        .rd_stream_ovf_o      (ovf)
    );

    fbs_ctrl_model i_fbs_ctrl_model (
        .clk_i      (clk),
        .ce_n_i     (ce_n),
        .wr_i       (wr),
        .wdata_i    (wdata),
        .dev_data_i ({pout, dout}),
        .dev_oe_b_i (oe_b),
        .lane_o     (lane),
        .clash_o    (clash)
    );

    task automatic chk(input string n, input logic [63:0] e,
                       input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop();
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One pin operation: 0 deselect, 1 read, 2 write, 3 advance, 4 suspend
    task automatic op(input int k, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] b, input logic o);
        logic [WORD_W-1:0] w;
        logic [WORD_W-1:0] m;
        logic [ADDR_W-1:0] x;
        logic              go;
        w = WORD_W'({$urandom, $urandom});
        x = a;
        @(posedge clk);
        go = (k == 3) && bopen;
        if (go) begin
            st = st + 2'h1;
            x = {bb[ADDR_W-1:2], ord ? bb[1:0] ^ st : bb[1:0] + st};
        end
        if (k == 1 || k == 2) begin
            bb = a;
            st = 2'h0;
            bw = (k == 2);
        end
        bopen = (k == 1 || k == 2) || (bopen && k != 0);
        if (k == 2 || (go && bw)) begin
            m = mem.exists(x) ? mem[x] : 'x;
            for (int i = 0; i < LANES; i++)
                if (!b[i]) begin
                    m[i*LANE_W +: LANE_W] = w[i*LANE_W +: LANE_W];
                    m[DATA_W+i] = w[DATA_W+i];
                end
            mem[x] = m;
        end
        if (k == 1 || (go && !bw)) begin
            if (!o) exp_pin.push_back(mem[x]);
            if (!drop) exp_str.push_back(mem[x]);
        end
        ce_n <= (k == 4);
        {cs1_n, cs2, cs3_n} <= (k == 0) ? DESEL[b[1:0]] : 3'h2;
        adv <= (k == 3);
        we_n <= (k != 2);
        bws_n <= b;
        oe_n <= o;
        addr <= a;
        wr <= (k == 2) || (go && bw);
        wdata <= w;
        rdy <= !stall && ($urandom % 4 != 0);
    endtask

    task automatic drain();
        for (int i = 0; i < 40 && exp_str.size() > 0; i++)
            op(0, 18'h00000, 4'h0, 1'b0);
        op(0, 18'h00000, 4'h0, 1'b0);
    endtask

    // Results are taken only at recognised edges
    always @(posedge clk) begin
        if (rst_b && !ce_n) begin
            `FBS_CHK("parity oe", oe_b, poe_b);
            if (clash) `FBS_CHK("lane clash", 1'b0, clash);
            if (oe_b === 1'b0 && exp_pin.size() == 0)
                `FBS_CHK("stray drive", 1'b1, oe_b);
            else if (oe_b === 1'b0)
                `FBS_CHK("pin word", exp_pin.pop_front(), {pout, dout});
            if (sv === 1'b1 && rdy && exp_str.size() == 0)
                `FBS_CHK("stray word", 1'b0, sv);
            else if (sv === 1'b1 && rdy)
                `FBS_CHK("stream word", exp_str.pop_front(), sd);
        end
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    initial begin
        logic [ADDR_W-1:0] a;
        void'($urandom(32'h532fa310));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int o = 0; o < 2; o++) begin
            op(0, 18'h00000, 4'h0, 1'b0);
            ord <= o[0];
            a = ADDR_W'(32'h100 + 8 * o + $urandom % 4);
            op(2, a, 4'h0, 1'b0);
            repeat (3) op(3, a, 4'h0, 1'b0);
            op(2, a, 4'($urandom), 1'b0);
            op(4, a, 4'h0, 1'b0);
            op(1, a, 4'h0, 1'b0);
            op(3, a, 4'h0, 1'b0);
            op(4, a, 4'h0, 1'b0);
            repeat (2) op(3, a, 4'h0, 1'b0);
            op(1, a, 4'h0, 1'b1);
            for (int i = 0; i < 3; i++) begin
                op(0, a, 4'(i), 1'b0);
                op(3, a, 4'h0, 1'b0);
                op(1, a ^ 18'h1, 4'h0, 1'b0);
            end
            op(2, a ^ 18'h2, 4'($urandom), 1'b0);
            op(1, a ^ 18'h2, 4'h0, 1'b0);
            op(2, a ^ 18'h3, 4'h0, 1'b0);
        end
        op(0, a, 4'h0, 1'b0);
        drain();
        `FBS_CHK("ovf clear", 1'b0, ovf);
        stall = 1'b1;
        for (int i = 0; i < 10; i++) begin
            drop = (i == 9);
            op((i % 4 == 0) ? 1 : 3, ADDR_W'(32'h100 + 8 * ((i / 4) % 2)),
               4'h0, 1'b0);
        end
        drop = 1'b0;
        repeat (2) op(0, a, 4'h0, 1'b0);
        `FBS_CHK("ovf set", 1'b1, ovf);
        stall = 1'b0;
        drain();
        `FBS_CHK("pins left", 0, exp_pin.size());
        `FBS_CHK("words left", 0, exp_str.size());
        report_and_stop();
    end
endmodule // fbs_sram_access_test
